// [pls_defs.svh]
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH

`define PLS_ADDR_PAR0         8'h00
`define PLS_ADDR_PAR1         8'h04
`define PLS_ADDR_PAR2         8'h08
`define PLS_ADDR_PAR3         8'h0C
`define PLS_ADDR_RATE         8'h10
`define PLS_ADDR_CTRL         8'h14
`define PLS_ADDR_ERRF         8'h18
`define PLS_ADDR_STAT         8'h1C
`define PLS_ADDR_SIZE         8'h20

`define PLS_MODE_PANEL        8'h03
`define PLS_PARITY_EVEN       8'h01
`define PLS_DATA_BITS         8'h08
`define PLS_STOP_BITS         8'h01
`define PLS_END_NONE          8'h00
`define PLS_MON_ALL           8'h0F
`define PLS_RATE_RESET        32'h0000_4B00
`define PLS_RETRY_LAST        3'h5
`define PLS_MAX_TELEGRAM      8'h8A

`define PLS_CMD_WRITE         8'h41
`define PLS_CMD_READ          8'h45
`define PLS_CMD_SPECIAL       8'h53
`define PLS_TCODE_DB          8'h44
`define PLS_TCODE_SPECIAL     8'h00

`define PLS_ERR_CTO_RX        8'h01
`define PLS_ERR_CTO_TX        8'h02
`define PLS_ERR_ACK_TO        8'h03
`define PLS_ERR_NO_START      8'h04
`define PLS_ERR_BAD_LEN       8'h05
`define PLS_ERR_START_GIVEUP  8'h06
`define PLS_ERR_START_NAK     8'h07
`define PLS_ERR_BLOCK_GIVEUP  8'h08
`define PLS_ERR_BLOCK_NAK     8'h09
`define PLS_ERR_NO_END        8'h0A
`define PLS_ERR_FAULTY_TX     8'h0B
`define PLS_ERR_CHAR          8'h0C
`define PLS_ERR_BADACK_START  8'h0D
`define PLS_ERR_BADACK_BLOCK  8'h0E
`define PLS_ERR_NO_BLOCK      8'h14
`define PLS_ERR_WR_BLOCK      8'h15
`define PLS_ERR_WR_TCODE      8'h16
`define PLS_ERR_SPECIAL       8'h17
`define PLS_ERR_RD_BLOCK      8'h18
`define PLS_ERR_RD_TCODE      8'h19
`define PLS_ERR_NOT_RW        8'h1A
`define PLS_ERR_NO_ADDR       8'h1B
`define PLS_ERR_COUNT         8'h1C

`define PLS_RESP_OKAY         2'h0
`define PLS_RESP_SLVERR       2'h2

`endif

// [pls_pkg.sv]
`default_nettype none
package pls_pkg;

  typedef enum logic [3:0] {
    LK_NONE, LK_CTO_RX, LK_CTO_TX, LK_ACK_TO, LK_NO_START, LK_BAD_LEN,
    LK_START_NAK, LK_BLOCK_NAK, LK_NO_END, LK_FAULTY_TX, LK_CHAR_ERR,
    LK_BADACK_START, LK_BADACK_BLOCK, LK_START_OK, LK_BLOCK_OK
  } pls_link_evt_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] tcode;
    logic [7:0] block;
    logic [7:0] count;
  } pls_req_t;

  typedef struct packed {
    logic       valid;
    logic       accept;
    logic       is_write;
    logic       special;
    logic       to_handling;
    logic [7:0] count;
    logic [7:0] code;
  } pls_grant_t;

  typedef struct packed {
    logic retry_start;
    logic retry_block;
    logic abandon;
  } pls_link_ctl_t;

  typedef struct packed {
    logic [7:0]  var_block;
    logic [7:0]  hnd_block;
    logic [3:0]  monitor;
    logic [31:0] line_rate;
  } pls_cfg_t;

endpackage : pls_pkg
`default_nettype wire

// [pls_slave.sv]
// What this block does
// - Requests reach only the variable block and the handling block.
// - First parameter word holds variable block low, handling block high.
// - Mode code 3 in second word low byte selects panel protocol.
// - Line format must be even parity, 8 data, 1 stop, no end char.
// - Monitoring value 15 enables every line supervision check.
// - Line rate comes from the final double-word parameter.
// - Each protocol error is written as a code into a free error byte; with both bytes full it is dropped.
// - A reported error puts the controller into its error state.
// - Codes 1, 2, 3 for receive, send and acknowledge timeouts.
// - Connection setup retried; code 7 per bad ack, code 6 after six.
// - Block send retried; code 9 per bad ack, code 8 after six.
// - Codes 4, 5, 10, 11, 12 for framing and character faults.
// - Codes 13 and 14 for inadmissible ack after start or block.
// - Code 20 when a configured block is missing or empty.
// - Write request: code 21 unknown block, 22 unknown telegram code.
// - Read request: code 24 unknown block, 25 unknown telegram code.
// - Code 23 bad special, 26 neither read nor write, 27 no block.
// - Code 28 when count exceeds block size or 138 bytes.
`include "pls_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pls_slave
  import pls_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          s_axi_awvalid,
  output var  logic          s_axi_awready,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_wvalid,
  output var  logic          s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  output var  logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output var  logic [1:0]    s_axi_bresp,
  input  wire logic          s_axi_arvalid,
  output var  logic          s_axi_arready,
  input  wire logic [7:0]    s_axi_araddr,
  output var  logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output var  logic [31:0]   s_axi_rdata,
  output var  logic [1:0]    s_axi_rresp,
  input  wire pls_link_evt_t link_evt,
  input  wire pls_req_t      req,
  output var  pls_grant_t    grant,
  output var  pls_link_ctl_t link_ctl,
  output var  pls_cfg_t      cfg,
  output var  logic          active,
  output var  logic          error_state
);

  logic          rst_meta_q;
  logic          rst_n_q;
  logic [15:0]   par_q [0:3];
  logic [31:0]   rate_q;
  logic          ctrl_act_q;
  logic [15:0]   size_q;
  logic [7:0]    e1_q;
  logic [7:0]    e2_q;
  logic [7:0]    e1_d;
  logic [7:0]    e2_d;
  logic [2:0]    st_cnt_q;
  logic [2:0]    st_cnt_d;
  logic [2:0]    bl_cnt_q;
  logic [2:0]    bl_cnt_d;
  logic [7:0]    lk_code;
  logic [7:0]    rq_code;
  pls_link_ctl_t ctl_d;
  logic [7:0]    aw_addr_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          do_write;
  logic          wr_err;
  logic          clr1;
  logic          clr2;
  logic          cfg_ok;
  logic [31:0]   rd_data;
  logic          rd_err;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [7:0] check_req(input pls_req_t   r,
                                           input logic [7:0] vb,
                                           input logic [7:0] hb,
                                           input logic [7:0] vs,
                                           input logic [7:0] hs);
    logic       wr;
    logic [7:0] sz;
    wr = (r.cmd == `PLS_CMD_WRITE);
    sz = (r.block == hb) ? hs : vs;
    if (r.cmd == `PLS_CMD_SPECIAL)
    begin
      return (r.tcode == `PLS_TCODE_SPECIAL) ? 8'h00 : `PLS_ERR_SPECIAL;
    end
    else if (!wr && r.cmd != `PLS_CMD_READ)
    begin
      return `PLS_ERR_NOT_RW;
    end
    else if (r.block == 8'h00)
    begin
      return `PLS_ERR_NO_ADDR;
    end
    else if (r.block != vb && r.block != hb)
    begin
      return wr ? `PLS_ERR_WR_BLOCK : `PLS_ERR_RD_BLOCK;
    end
    else if (r.tcode != `PLS_TCODE_DB)
    begin
      return wr ? `PLS_ERR_WR_TCODE : `PLS_ERR_RD_TCODE;
    end
    else if (sz == 8'h00)
    begin
      return `PLS_ERR_NO_BLOCK;
    end
    else if (r.count > sz || r.count > `PLS_MAX_TELEGRAM)
    begin
      return `PLS_ERR_COUNT;
    end
    return 8'h00;
  endfunction : check_req

  // The release is synchronised so every flop leaves reset on one edge.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign clr1 = do_write && aw_addr_q == `PLS_ADDR_ERRF && w_strb_q[0] &&
                w_data_q[7:0] == 8'h00;
  assign clr2 = do_write && aw_addr_q == `PLS_ADDR_ERRF && w_strb_q[1] &&
                w_data_q[15:8] == 8'h00;

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PLS_RESP_OKAY;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr_q     <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      else if (do_write)
      begin
        s_axi_wready <= 1'b1;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? `PLS_RESP_SLVERR : `PLS_RESP_OKAY;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    wr_err = 1'b0;
    if (aw_addr_q > `PLS_ADDR_SIZE || aw_addr_q[1:0] != 2'h0 ||
        aw_addr_q == `PLS_ADDR_STAT)
    begin
      wr_err = 1'b1;
    end
  end

  // Parameter words take writes at any time; active and cfg follow them one cycle later.
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int i = 0; i < 4; i++)
      begin
        par_q[i] <= 16'h0000;
      end
      rate_q     <= `PLS_RATE_RESET;
      ctrl_act_q <= 1'b0;
      size_q     <= 16'h0000;
    end
    else if (do_write && !wr_err)
    begin
      if (aw_addr_q < `PLS_ADDR_RATE)
      begin
        par_q[aw_addr_q[3:2]] <= 16'(merge({16'h0000, par_q[aw_addr_q[3:2]]},
                                           w_data_q, w_strb_q));
      end
      else if (aw_addr_q == `PLS_ADDR_RATE)
      begin
        rate_q <= merge(rate_q, w_data_q, w_strb_q);
      end
      else if (aw_addr_q == `PLS_ADDR_CTRL)
      begin
        if (w_strb_q[0])
        begin
          ctrl_act_q <= w_data_q[0];
        end
      end
      else if (aw_addr_q == `PLS_ADDR_SIZE)
      begin
        size_q <= 16'(merge({16'h0000, size_q}, w_data_q, w_strb_q));
      end
    end
  end

  assign cfg_ok = par_q[1][15:8] == `PLS_PARITY_EVEN &&
                  par_q[2][7:0] == `PLS_DATA_BITS &&
                  par_q[2][15:8] == `PLS_STOP_BITS &&
                  par_q[3][7:0] == `PLS_END_NONE;

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      active <= 1'b0;
      cfg    <= '0;
    end
    else
    begin
      active <= ctrl_act_q && par_q[1][7:0] == `PLS_MODE_PANEL && cfg_ok;
      cfg.var_block <= par_q[0][7:0];
      cfg.hnd_block <= par_q[0][15:8];
      cfg.monitor   <= par_q[3][11:8];
      cfg.line_rate <= rate_q;
    end
  end

  // Timeouts need the receiver check; character faults need any other.
  always_comb
  begin
    lk_code  = 8'h00;
    st_cnt_d = st_cnt_q;
    bl_cnt_d = bl_cnt_q;
    ctl_d    = '0;
    if (active)
    begin
      case (link_evt)
        LK_CTO_RX:       lk_code = cfg.monitor[0] ? `PLS_ERR_CTO_RX : 8'h00;
        LK_CTO_TX:       lk_code = cfg.monitor[0] ? `PLS_ERR_CTO_TX : 8'h00;
        LK_ACK_TO:       lk_code = cfg.monitor[0] ? `PLS_ERR_ACK_TO : 8'h00;
        LK_NO_START:     lk_code = `PLS_ERR_NO_START;
        LK_BAD_LEN:      lk_code = `PLS_ERR_BAD_LEN;
        LK_NO_END:       lk_code = `PLS_ERR_NO_END;
        LK_FAULTY_TX:    lk_code = `PLS_ERR_FAULTY_TX;
        LK_CHAR_ERR:     lk_code = |cfg.monitor[3:1] ? `PLS_ERR_CHAR : 8'h00;
        LK_BADACK_START: lk_code = `PLS_ERR_BADACK_START;
        LK_BADACK_BLOCK: lk_code = `PLS_ERR_BADACK_BLOCK;
        LK_START_NAK:
        begin
          if (st_cnt_q == `PLS_RETRY_LAST)
          begin
            lk_code       = `PLS_ERR_START_GIVEUP;
            st_cnt_d      = 3'h0;
            ctl_d.abandon = 1'b1;
          end
          else
          begin
            lk_code           = `PLS_ERR_START_NAK;
            st_cnt_d          = st_cnt_q + 3'h1;
            ctl_d.retry_start = 1'b1;
          end
        end
        LK_BLOCK_NAK:
        begin
          if (bl_cnt_q == `PLS_RETRY_LAST)
          begin
            lk_code       = `PLS_ERR_BLOCK_GIVEUP;
            bl_cnt_d      = 3'h0;
            ctl_d.abandon = 1'b1;
          end
          else
          begin
            lk_code           = `PLS_ERR_BLOCK_NAK;
            bl_cnt_d          = bl_cnt_q + 3'h1;
            ctl_d.retry_block = 1'b1;
          end
        end
        LK_START_OK:     st_cnt_d = 3'h0;
        LK_BLOCK_OK:     bl_cnt_d = 3'h0;
        default:         lk_code = 8'h00;
      endcase
    end
  end

  assign rq_code = (active && req.valid) ?
                   check_req(req, cfg.var_block, cfg.hnd_block,
                             size_q[7:0], size_q[15:8]) : 8'h00;

  // A clear and a new code in one cycle keep the code; a third code
  // arriving while both bytes are occupied is dropped.
  always_comb
  begin
    e1_d = clr1 ? 8'h00 : e1_q;
    e2_d = clr2 ? 8'h00 : e2_q;
    if (lk_code != 8'h00)
    begin
      if (e1_d == 8'h00)
      begin
        e1_d = lk_code;
      end
      else if (e2_d == 8'h00)
      begin
        e2_d = lk_code;
      end
    end
    if (rq_code != 8'h00)
    begin
      if (e1_d == 8'h00)
      begin
        e1_d = rq_code;
      end
      else if (e2_d == 8'h00)
      begin
        e2_d = rq_code;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      e1_q        <= 8'h00;
      e2_q        <= 8'h00;
      st_cnt_q    <= 3'h0;
      bl_cnt_q    <= 3'h0;
      link_ctl    <= '0;
      error_state <= 1'b0;
    end
    else
    begin
      e1_q        <= e1_d;
      e2_q        <= e2_d;
      st_cnt_q    <= st_cnt_d;
      bl_cnt_q    <= bl_cnt_d;
      link_ctl    <= ctl_d;
      error_state <= active && (e1_q != 8'h00 || e2_q != 8'h00);
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      grant <= '0;
    end
    else
    begin
      grant.valid       <= active && req.valid;
      grant.accept      <= active && req.valid && rq_code == 8'h00;
      grant.is_write    <= req.cmd == `PLS_CMD_WRITE;
      grant.special     <= req.cmd == `PLS_CMD_SPECIAL;
      grant.to_handling <= req.block == cfg.hnd_block;
      grant.count       <= req.count;
      grant.code        <= rq_code;
    end
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (s_axi_araddr[1:0] != 2'h0)
    begin
      rd_err = 1'b1;
    end
    else if (s_axi_araddr < `PLS_ADDR_RATE)
    begin
      rd_data = {16'h0000, par_q[s_axi_araddr[3:2]]};
    end
    else if (s_axi_araddr == `PLS_ADDR_RATE)
    begin
      rd_data = rate_q;
    end
    else if (s_axi_araddr == `PLS_ADDR_CTRL)
    begin
      rd_data = {31'h0000_0000, ctrl_act_q};
    end
    else if (s_axi_araddr == `PLS_ADDR_ERRF)
    begin
      rd_data = {16'h0000, e2_q, e1_q};
    end
    else if (s_axi_araddr == `PLS_ADDR_STAT)
    begin
      rd_data = {22'h00_0000, bl_cnt_q, st_cnt_q, 1'b0, cfg_ok, error_state,
                 active};
    end
    else if (s_axi_araddr == `PLS_ADDR_SIZE)
    begin
      rd_data = {16'h0000, size_q};
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PLS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? `PLS_RESP_SLVERR : `PLS_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  property p_code_held;
    @(posedge clock) disable iff (!rst_n_q)
    (e1_q != 8'h00 && !clr1) |=> e1_q == $past(e1_q);
  endproperty
  a_code_held: assert property (p_code_held)
    else $error("error byte changed without a clear");

  property p_clear;
    @(posedge clock) disable iff (!rst_n_q)
    (clr1 && lk_code == 8'h00 && rq_code == 8'h00) |=> e1_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("zero write did not clear the first error byte");

  property p_err_state;
    @(posedge clock) disable iff (!rst_n_q)
    (active && e2_q != 8'h00) |=> error_state;
  endproperty
  a_err_state: assert property (p_err_state)
    else $error("error state missing while a code is held");

  property p_rx_timeout;
    @(posedge clock) disable iff (!rst_n_q)
    (active && cfg.monitor[0] && link_evt == LK_CTO_RX && e1_q == 8'h00)
      |=> e1_q == `PLS_ERR_CTO_RX;
  endproperty
  a_rx_timeout: assert property (p_rx_timeout)
    else $error("receive timeout not reported as code 1");

  property p_start_giveup;
    @(posedge clock) disable iff (!rst_n_q)
    (active && link_evt == LK_START_NAK && st_cnt_q == 3'h5 &&
     e1_q == 8'h00 && !clr1) |=> e1_q == `PLS_ERR_START_GIVEUP &&
     link_ctl.abandon && st_cnt_q == 3'h0;
  endproperty
  a_start_giveup: assert property (p_start_giveup)
    else $error("sixth bad start ack not reported as code 6");

  property p_block_retry;
    @(posedge clock) disable iff (!rst_n_q)
    (active && link_evt == LK_BLOCK_NAK && bl_cnt_q < 3'h5)
      |=> link_ctl.retry_block && bl_cnt_q == $past(bl_cnt_q) + 3'h1;
  endproperty
  a_block_retry: assert property (p_block_retry)
    else $error("bad block ack did not cause a retry");

  property p_only_two;
    @(posedge clock) disable iff (!rst_n_q)
    (grant.accept && !grant.special) |->
      $past(req.block) == $past(cfg.var_block) ||
      $past(req.block) == $past(cfg.hnd_block);
  endproperty
  a_only_two: assert property (p_only_two)
    else $error("access granted to a foreign block");

  property p_count;
    @(posedge clock) disable iff (!rst_n_q)
    grant.accept |-> grant.count <= 8'h8A;
  endproperty
  a_count: assert property (p_count)
    else $error("telegram above 138 bytes was granted");

  property p_mode;
    @(posedge clock) disable iff (!rst_n_q)
    active |-> $past(par_q[1][7:0]) == 8'h03 && $past(cfg_ok);
  endproperty
  a_mode: assert property (p_mode)
    else $error("active without panel mode and line format");

endmodule : pls_slave
`default_nettype wire

// [pls_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pls_panel_model
  import pls_pkg::*;
(
  input  wire logic          clock,
  output var  pls_link_evt_t link_evt,
  output var  pls_req_t      req
);
  initial
  begin
    link_evt = LK_NONE;
    req      = '0;
  end

  task automatic evt(input pls_link_evt_t e);
    @(posedge clock);
    link_evt <= e;
    @(posedge clock);
    link_evt <= LK_NONE;
  endtask : evt

  // Idle request fields carry inverted junk, so a stale value is never
  // taken for a live request.
  task automatic ask(input logic [31:0] f);
    @(posedge clock);
    req <= {1'b1, f};
    @(posedge clock);
    req <= {1'b0, ~f};
  endtask : ask
endmodule : pls_panel_model
`default_nettype wire

// [tb.sv]
`include "pls_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb
  import pls_pkg::*;
  ;
  logic          clock;
  logic          resetn;
  logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_rready;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic          s_axi_arready, s_axi_rvalid;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rr;
  pls_link_evt_t link_evt;
  pls_req_t      req;
  pls_grant_t    grant;
  pls_link_ctl_t link_ctl;
  pls_cfg_t      cfg;
  logic          active, error_state;
  int            err_total, num_checks, i, k;
  logic [95:0]   cd = 96'h01020304050A0B0C0D0E0709;
  pls_link_evt_t ev [12] = '{LK_CTO_RX, LK_CTO_TX, LK_ACK_TO, LK_NO_START,
    LK_BAD_LEN, LK_NO_END, LK_FAULTY_TX, LK_CHAR_ERR, LK_BADACK_START,
    LK_BADACK_BLOCK, LK_START_NAK, LK_BLOCK_NAK};
  logic [39:0]   rq [14] = '{40'h4544334000, 40'h4144322000, 40'h5300000000,
    40'h5301330117, 40'h504433011A, 40'h454400011B, 40'h4144070115,
    40'h4544070118, 40'h4155330116, 40'h4555330119, 40'h454433411C,
    40'h4144320114, 40'h4544338A00, 40'h4544338B1C};

  pls_slave pls_slave_inst (.clock, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .link_evt, .req, .grant, .link_ctl, .cfg,
    .active, .error_state);
  pls_panel_model pls_panel_model_inst (.clock, .link_evt, .req);

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic results;
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  // Both masters hold ready high from the start, so the answer is taken
  // at the first edge where it is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rr = s_axi_bresp;
    if (n == 50)
    begin
      err_total++;
      results();
    end
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    int n;
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    if (n == 50)
    begin
      err_total++;
      results();
    end
  endtask : rdw

  task automatic ec(input logic [15:0] e);
    rdw(`PLS_ADDR_ERRF);
    chk(rd, {16'h0000, e});
    chk(32'(error_state), 32'(e != 16'h0000));
    wr(`PLS_ADDR_ERRF, 32'h0000_0000, 4'h3);
  endtask : ec

  initial
  begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
    err_total = 0;
    num_checks = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rdw(`PLS_ADDR_RATE);
    chk(rd, `PLS_RATE_RESET);
    rdw(8'h24);
    chk(rd, 32'h0000_0000);
    chk(32'(rr), 32'(`PLS_RESP_SLVERR));
    wr(`PLS_ADDR_STAT, 32'h0000_0001, 4'hF);
    chk(32'(rr), 32'(`PLS_RESP_SLVERR));
    // A wrong mode code leaves the block idle and deaf to the link.
    wr(`PLS_ADDR_PAR0, 32'h0000_3233, 4'hF);
    wr(`PLS_ADDR_PAR1, 32'h0000_0104, 4'hF);
    wr(`PLS_ADDR_PAR2, 32'h0000_0108, 4'hF);
    wr(`PLS_ADDR_PAR3, 32'h0000_0F00, 4'hF);
    wr(`PLS_ADDR_RATE, 32'h0000_2580, 4'hF);
    wr(`PLS_ADDR_SIZE, 32'h0000_2040, 4'hF);
    wr(`PLS_ADDR_CTRL, 32'h0000_0001, 4'hF);
    pls_panel_model_inst.evt(LK_CTO_RX);
    rdw(`PLS_ADDR_STAT);
    chk(rd & 32'h7, 32'h4);
    ec(16'h0000);
    wr(`PLS_ADDR_PAR1, 32'h0000_0103, 4'hF);
    wr(`PLS_ADDR_CTRL, 32'h0000_0001, 4'hF);
    rdw(`PLS_ADDR_STAT);
    chk(rd & 32'h7, 32'h5);
    chk({cfg.var_block, cfg.hnd_block, 12'h0, cfg.monitor}, 32'h3332000F);
    chk(cfg.line_rate, 32'h0000_2580);
    for (i = 0; i < 12; i++)
    begin
      pls_panel_model_inst.evt(ev[i]);
      ec({8'h00, cd[95-8*i -: 8]});
    end
    for (k = 0; k < 2; k++)
    begin
      pls_panel_model_inst.evt(k ? LK_BLOCK_OK : LK_START_OK);
      for (i = 0; i < 6; i++)
      begin
        pls_panel_model_inst.evt(k ? LK_BLOCK_NAK : LK_START_NAK);
        #1;
        chk(32'(link_ctl), i == 5 ? 32'h1 : (k ? 32'h2 : 32'h4));
        ec(i == 5 ? (k ? 16'h8 : 16'h6) : (k ? 16'h9 : 16'h7));
      end
    end
    // Third code is dropped; a nonzero write must not disturb the bytes.
    pls_panel_model_inst.evt(LK_CTO_TX);
    pls_panel_model_inst.evt(LK_ACK_TO);
    pls_panel_model_inst.evt(LK_NO_END);
    wr(`PLS_ADDR_ERRF, 32'h0000_0505, 4'h3);
    rdw(`PLS_ADDR_ERRF);
    chk(rd, 32'h0000_0302);
    wr(`PLS_ADDR_ERRF, 32'h0000_0000, 4'h1);
    ec(16'h0300);
    ec(16'h0000);
    for (i = 0; i < 14; i++)
    begin
      if (i == 11) wr(`PLS_ADDR_SIZE, 32'h0000_00FF, 4'hF);
      pls_panel_model_inst.ask(rq[i][39:8]);
      #1;
      chk(32'({grant.valid, grant.accept, grant.code}),
          32'({1'b1, rq[i][7:0] == 8'h00, rq[i][7:0]}));
      chk(32'({grant.is_write, grant.special, grant.to_handling,
               grant.count}), 32'({rq[i][39:32] == `PLS_CMD_WRITE,
          rq[i][39:32] == `PLS_CMD_SPECIAL, rq[i][23:16] == 8'h32,
          rq[i][15:8]}));
      ec({8'h00, rq[i][7:0]});
    end
    wr(`PLS_ADDR_PAR3, 32'h0000_0000, 4'hF);
    pls_panel_model_inst.evt(LK_CTO_RX);
    pls_panel_model_inst.evt(LK_CHAR_ERR);
    ec(16'h0000);
    results();
  end
endmodule : tb
`default_nettype wire
